// *** design/rpp_consts.vh ***
// Constants for the receive path processor indirect access register bank.
// Included by the register bank and its RAM engine; definitions only.
`ifndef RPP_CONSTS_VH
`define RPP_CONSTS_VH

// Register indices and byte addresses (index times four)
`define RPP_IDX_ADDR        12'h100
`define RPP_IDX_DATA        12'h101
`define RPP_IDX_PCFG        12'h102
`define RPP_BA_ADDR         14'h0400
`define RPP_BA_DATA         14'h0404
`define RPP_BA_PCFG         14'h0408

// Address register fields
`define RPP_A_BUSY          15
`define RPP_A_RNW           14
`define RPP_A_LOC_HI        9
`define RPP_A_LOC_LO        6
`define RPP_A_PATH_HI       3
`define RPP_A_PATH_LO       0
`define RPP_A_RW_MASK       16'h43cf

// Payload configuration fields
`define RPP_P_SLAVE         15
`define RPP_P_CONC12        14
`define RPP_P_RSV_MASK      16'h21f0
`define RPP_P_RW_MASK       16'hc1ff

// Reset values
`define RPP_ADDR_RST        16'h0000
`define RPP_DATA_RST        16'h0000
`define RPP_PCFG_RST        16'h0000

// Path and location codes
`define RPP_PATH_FIRST      4'h1
`define RPP_PATH_LAST       4'hc
`define RPP_LOC_LAST        4'h9
`define RPP_LOC_CNT         10

// Busy timing: longest access in clock cycles, and the cycles this engine uses
`define RPP_BUSY_MAX_CYC    22
`define RPP_ACCESS_CYC      5'd4

// AXI responses
`define RPP_RESP_OKAY       2'b00
`define RPP_RESP_SLVERR     2'b10

`endif

// *** design/rpp_ram_engine.v ***
// Indirect RAM for twelve paths with ten words each, and its access sequencer.
// Assumes one start pulse per access, given only while not busy.
`timescale 1ns/1ps
`include "rpp_consts.vh"

module rpp_ram_engine #(
	parameter DW = 16
) (
	// Clock and reset
	input  wire          clk,
	input  wire          rst_n,
	// Access request
	input  wire          start,
	input  wire          rnw,
	input  wire [3:0]    path,
	input  wire [3:0]    loc,
	input  wire [DW-1:0] wdata,
	// Completion
	output reg           busy_r,
	output reg           done_r,
	output reg           rd_valid_r,
	output reg  [DW-1:0] rdata_r
);

	reg [DW-1:0] mem [0:12*`RPP_LOC_CNT-1];
	reg [4:0]    cnt_r;
	reg          rnw_r;
	reg          ok_r;
	reg [6:0]    idx_r;
	reg [DW-1:0] wd_r;
	wire         path_ok;
	wire         loc_ok;
	wire [6:0]   path_base;
	wire [6:0]   idx;

	assign path_ok   = (path >= `RPP_PATH_FIRST) && (path <= `RPP_PATH_LAST);
	assign loc_ok    = (loc <= `RPP_LOC_LAST);
	assign path_base = {3'h0, path - 4'h1} * 7'd10;
	assign idx       = path_base + {3'h0, loc};

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r     <= 1'b0;
			done_r     <= 1'b0;
			rd_valid_r <= 1'b0;
			rdata_r    <= {DW{1'b0}};
			cnt_r      <= 5'd0;
			rnw_r      <= 1'b0;
			ok_r       <= 1'b0;
			idx_r      <= 7'd0;
			wd_r       <= {DW{1'b0}};
		end else begin
			done_r     <= 1'b0;
			rd_valid_r <= 1'b0;
			if (start) begin
				busy_r <= 1'b1;
				cnt_r  <= `RPP_ACCESS_CYC;
				rnw_r  <= rnw;
				ok_r   <= path_ok && loc_ok;
				idx_r  <= idx;
				wd_r   <= wdata;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 5'd1;
				if (cnt_r == 5'd1) begin
					busy_r     <= 1'b0;
					done_r     <= 1'b1;
					rd_valid_r <= rnw_r;
					rdata_r    <= ok_r ? mem[idx_r] : {DW{1'b0}};
				end
			end
		end
	end

	// Word storage has no reset; invalid targets are dropped
	always @(posedge clk) begin
		if (busy_r && !start && cnt_r == 5'd1 && !rnw_r && ok_r) begin
			mem[idx_r] <= wd_r;
		end
	end

endmodule

// *** design/rpp_path_access_regs.v ***
// AXI4-Lite register bank: indirect address, indirect data, payload configuration.
// Assumes a single clock; rst_n is asynchronous and released here in sync.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rpp_consts.vh"

// Summary of operation
// - Path codes 1..12 valid, others invalid
// - Location codes 0..9 used, 10..15 unused
// - Address write starts one indirect RAM access
// - Read select 1 copies RAM into data
// - Read select 0 copies data into RAM
// - Busy sets on address write, clears after
// - Access finishes within 22 clock cycles
// - Triple bit n joins paths n, n+4, n+8
// - Twelve-path bit overrides triple grouping
// - Slave select marks twelve-path payload slave
// - Data word meaning follows addressed location
module rpp_path_access_regs #(
	parameter AW = 14
) (
	// Clock and reset
	input  wire          sys_clk,
	input  wire          rst_n,
	// AXI4-Lite write address
	input  wire [AW-1:0] s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	// AXI4-Lite read address
	input  wire [AW-1:0] s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	// Payload grouping and access busy to the path logic
	output reg  [11:0]   path_in_triple_r,
	output reg  [11:0]   path_in_twelve_r,
	output reg           concat_slave_r,
	output reg           access_busy_r
);

	reg         rst_s1_r;
	reg         rst_s2_r;
	wire        rstn;
	reg  [15:0] addr_r;
	reg  [15:0] data_r;
	reg  [15:0] pcfg_r;
	reg  [AW-1:0] aw_r;
	reg  [31:0] w_r;
	reg  [3:0]  ws_r;
	reg         aw_have_r;
	reg         w_have_r;
	reg         start_r;
	wire        busy;
	wire        done;
	wire        rd_valid;
	wire [15:0] rdata;
	wire        wr_go;
	wire        wr_addr;
	wire        wr_data;
	wire        wr_pcfg;
	wire        wr_hit;
	wire [15:0] wv;
	wire [15:0] wmask;
	wire        rd_addr;
	wire        rd_data;
	wire        rd_pcfg;
	wire        busy_flag;
	reg  [15:0] rd_val;
	reg         rd_ok;
	wire [3:0]  triple_concat_group;
	wire        twelve_path_concat;

	// Reset release
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rstn = rst_s2_r;

	// Indirect RAM and its access sequencer
	rpp_ram_engine #(
		.DW(16)
	) u_eng (
		.clk       (sys_clk),
		.rst_n     (rstn),
		.start     (start_r),
		.rnw       (addr_r[`RPP_A_RNW]),
		.path      (addr_r[`RPP_A_PATH_HI:`RPP_A_PATH_LO]),
		.loc       (addr_r[`RPP_A_LOC_HI:`RPP_A_LOC_LO]),
		.wdata     (data_r),
		.busy_r    (busy),
		.done_r    (done),
		.rd_valid_r(rd_valid),
		.rdata_r   (rdata)
	);

	// Write channel: address and data captured in either order
	assign wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wmask   = {{8{ws_r[1]}}, {8{ws_r[0]}}};
	assign wv      = w_r[15:0];
	assign wr_addr = (aw_r[AW-1:2] == `RPP_IDX_ADDR);
	assign wr_data = (aw_r[AW-1:2] == `RPP_IDX_DATA);
	assign wr_pcfg = (aw_r[AW-1:2] == `RPP_IDX_PCFG);
	assign wr_hit  = wr_addr || wr_data || wr_pcfg;

	// Write address: not taken again until the response is accepted
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			aw_have_r     <= 1'b0;
			aw_r          <= {AW{1'b0}};
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_r          <= s_axi_awaddr;
				aw_have_r     <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	// Write data: not taken again until the response is accepted
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_wready <= 1'b1;
			w_have_r     <= 1'b0;
			w_r          <= 32'h0000_0000;
			ws_r         <= 4'h0;
		end else begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_r          <= s_axi_wdata;
				ws_r         <= s_axi_wstrb;
				w_have_r     <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write response: unmapped addresses answer with an error
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RPP_RESP_OKAY;
		end else begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RPP_RESP_OKAY : `RPP_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register updates; a bus write to the data register beats a RAM read result
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			addr_r  <= `RPP_ADDR_RST;
			data_r  <= `RPP_DATA_RST;
			pcfg_r  <= `RPP_PCFG_RST;
			start_r <= 1'b0;
		end else begin
			start_r <= wr_go && wr_addr;
			if (wr_go && wr_addr) begin
				addr_r <= (addr_r & ~wmask) | (wv & wmask & `RPP_A_RW_MASK);
			end
			if (wr_go && wr_data) begin
				data_r <= (data_r & ~wmask) | (wv & wmask);
			end else if (rd_valid) begin
				data_r <= rdata;
			end
			if (wr_go && wr_pcfg) begin
				pcfg_r <= (pcfg_r & ~wmask) | (wv & wmask & `RPP_P_RW_MASK);
			end
		end
	end

	// Read decode
	assign rd_addr   = (s_axi_araddr[AW-1:2] == `RPP_IDX_ADDR);
	assign rd_data   = (s_axi_araddr[AW-1:2] == `RPP_IDX_DATA);
	assign rd_pcfg   = (s_axi_araddr[AW-1:2] == `RPP_IDX_PCFG);
	assign busy_flag = busy || start_r;

	// Busy reads high from the address write until the access ends
	always @* begin
		rd_val = 16'h0000;
		rd_ok  = 1'b1;
		if (rd_addr) begin
			rd_val = addr_r;
			rd_val[`RPP_A_BUSY] = busy_flag;
		end else if (rd_data) begin
			rd_val = data_r;
		end else if (rd_pcfg) begin
			rd_val = pcfg_r;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read address: not taken again until the read data is accepted
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Read data: captured at the address handshake, held until accepted
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RPP_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {16'h0000, rd_val};
				s_axi_rresp  <= rd_ok ? `RPP_RESP_OKAY : `RPP_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Payload grouping
	assign triple_concat_group = pcfg_r[3:0];
	assign twelve_path_concat  = pcfg_r[`RPP_P_CONC12];

	genvar g;
	generate
		for (g = 0; g < 12; g = g + 1) begin : g_path
			always @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					path_in_triple_r[g] <= 1'b0;
					path_in_twelve_r[g] <= 1'b0;
				end else begin
					path_in_twelve_r[g] <= twelve_path_concat;
					path_in_triple_r[g] <= !twelve_path_concat
						&& triple_concat_group[g % 4];
				end
			end
		end
	endgenerate

	// Slave marking applies only to a twelve-path payload
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			concat_slave_r <= 1'b0;
		end else begin
			concat_slave_r <= twelve_path_concat && pcfg_r[`RPP_P_SLAVE];
		end
	end

	// Busy copy for the path logic, one cycle behind the register view
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			access_busy_r <= 1'b0;
		end else begin
			access_busy_r <= busy_flag;
		end
	end

endmodule

// *** tb/rpp_checker_sva.sv ***
// Checker for the path access register bank, bound to its ports.
// Assumes one clock and an active-low reset.
`timescale 1ns/1ps
`include "rpp_consts.vh"
module rpp_checker #(
	parameter AW = 14
) (
	input wire          sys_clk,
	input wire          rst_n,
	input wire [AW-1:0] s_axi_awaddr,
	input wire          s_axi_awvalid,
	input wire          s_axi_awready,
	input wire [31:0]   s_axi_wdata,
	input wire          s_axi_wvalid,
	input wire          s_axi_wready,
	input wire          s_axi_bvalid,
	input wire [11:0]   path_in_triple_r,
	input wire [11:0]   path_in_twelve_r,
	input wire          concat_slave_r,
	input wire          access_busy_r
);
	reg [AW-1:0] aw_r;
	reg [15:0]   w_r;
	reg [5:0]    bc_r;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_r <= '0;
			w_r <= 16'h0;
			bc_r <= 6'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) w_r <= s_axi_wdata[15:0];
			bc_r <= access_busy_r ? bc_r + {5'h0, bc_r != 6'h3f} : 6'h0;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence addr_wr;
		$rose(s_axi_bvalid) && aw_r == `RPP_BA_ADDR;
	endsequence
	sequence cfg_wr;
		$rose(s_axi_bvalid) && aw_r == `RPP_BA_PCFG;
	endsequence
	busy_set_a: assert property (addr_wr |-> ##[0:3] access_busy_r)
		else $error("busy not raised");
	busy_max_a: assert property (bc_r <= 6'h16)
		else $error("busy too long");
	busy_start_a: assert property ($rose(access_busy_r) |->
		s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("busy without write");
	group_excl_a: assert property ((path_in_triple_r & path_in_twelve_r) == 12'h0)
		else $error("path in two groups");
	triple_rep_a: assert property (path_in_triple_r[3:0] == path_in_triple_r[7:4]
		&& path_in_triple_r[7:4] == path_in_triple_r[11:8])
		else $error("triple pattern");
	slave_twelve_a: assert property (concat_slave_r |-> path_in_twelve_r == 12'hfff)
		else $error("slave without twelve");
	cfg_twelve_a: assert property (cfg_wr |-> ##[0:2] path_in_twelve_r == {12{w_r[14]}})
		else $error("twelve grouping");
	cfg_triple_a: assert property (cfg_wr |->
		##[0:2] path_in_triple_r == ({3{w_r[3:0]}} & {12{!w_r[14]}}))
		else $error("triple grouping");
	cfg_slave_a: assert property (cfg_wr |-> ##[0:2] concat_slave_r == (w_r[15] & w_r[14]))
		else $error("slave select");
endmodule
bind rpp_path_access_regs rpp_checker #(.AW(AW)) u_chk (.sys_clk, .rst_n, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .path_in_triple_r, .path_in_twelve_r, .concat_slave_r, .access_busy_r);

// *** tb/testbench.sv ***
// Self-checking bench for the path access register bank.
// Assumes the design and the checker are compiled first.
`timescale 1ns/1ps
`include "rpp_consts.vh"
module testbench;
	reg         sys_clk = 1'h0;
	reg         rst_n = 1'h0;
	reg  [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hf;
	reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [11:0] path_in_triple_r, path_in_twelve_r;
	wire        concat_slave_r, access_busy_r;
	integer     n_mismatch = 0, n_checks = 0, cyc = 0;
	reg  [31:0] q;
	reg  [1:0]  rs;
	rpp_path_access_regs #(.AW(14)) dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.path_in_triple_r, .path_in_twelve_r, .concat_slave_r, .access_busy_r);
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run;
		end
	end
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input [31:0] got, input [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task wr(input [13:0] a, input [15:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		rs = s_axi_bresp;
	endtask
	task rd(input [13:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		q = s_axi_rdata;
		rs = s_axi_rresp;
	endtask
	task ind(input rnw, input [3:0] p, input [3:0] l, input [15:0] d);
		reg [15:0] a;
		a = {1'h0, rnw, 4'h0, l, 2'h0, p};
		if (!rnw) wr(`RPP_BA_DATA, d);
		wr(`RPP_BA_ADDR, a);
		rd(`RPP_BA_ADDR);
		chk("busy", q[15], 1'h1);
		chk("busy out", access_busy_r, 1'h1);
		while (q[15] === 1'h1) rd(`RPP_BA_ADDR);
		chk("idle out", access_busy_r, 1'h0);
		chk("addr", q, {16'h0, a});
		if (rnw) begin
			rd(`RPP_BA_DATA);
			chk("rdata", q, {16'h0, d});
		end
	endtask
	task t_reset;
		integer i;
		for (i = 0; i < 3; i++) begin
			rd(`RPP_BA_ADDR + 14'(4 * i));
			chk("rst", q, 32'h0);
			chk("resp", rs, `RPP_RESP_OKAY);
		end
		rd(14'h040c);
		chk("bad rd", {q[29:0], rs}, {30'h0, `RPP_RESP_SLVERR});
		wr(14'h0410, 16'h1234);
		chk("bad wr", rs, `RPP_RESP_SLVERR);
		s_axi_wstrb <= 4'h1;
		wr(`RPP_BA_DATA, 16'habcd);
		s_axi_wstrb <= 4'hf;
		rd(`RPP_BA_DATA);
		chk("strobe", q, 32'h0000_00cd);
	endtask
	task t_midrst;
		wr(`RPP_BA_PCFG, 16'h000f);
		wr(`RPP_BA_DATA, 16'h5a5a);
		rst_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge sys_clk);
		chk("rst triple", path_in_triple_r, 32'h0);
		rd(`RPP_BA_PCFG);
		chk("rst pcfg", q, 32'h0);
		rd(`RPP_BA_DATA);
		chk("rst data", q, 32'h0);
	endtask
	task t_ram(input rnw);
		integer p, l;
		for (p = 1; p < 13; p++)
			for (l = 0; l < 10; l++)
				ind(rnw, 4'(p), 4'(l), {4'(p), 4'(l), ~4'(p), ~4'(l)});
	endtask
	task t_bad;
		ind(1'h0, 4'h0, 4'h0, 16'h1111);
		ind(1'h0, 4'hd, 4'h0, 16'h2222);
		ind(1'h0, 4'h1, 4'ha, 16'h3333);
		ind(1'h1, 4'h0, 4'h0, 16'h0);
		ind(1'h1, 4'hf, 4'h2, 16'h0);
		ind(1'h1, 4'hc, 4'hf, 16'h0);
	endtask
	task t_pcfg;
		reg [15:0] v[9];
		integer i;
		v = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h000a, 16'h000f,
			16'h4000, 16'hc000, 16'h0000};
		for (i = 0; i < 9; i++) begin
			wr(`RPP_BA_PCFG, v[i]);
			rd(`RPP_BA_PCFG);
			chk("pcfg", q, {16'h0, v[i] & `RPP_P_RW_MASK});
			chk("twelve", path_in_twelve_r, {12{v[i][14]}});
			chk("triple", path_in_triple_r, {3{v[i][3:0]}} & {12{!v[i][14]}});
			chk("slave", concat_slave_r, v[i][15] & v[i][14]);
		end
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge sys_clk);
		t_reset;
		t_ram(1'h0);
		t_bad;
		t_ram(1'h1);
		t_pcfg;
		t_midrst;
		complete_run;
	end
endmodule
